// *** fos_host.sv ***
// Host sequencer driving a 16-bit NOR flash for program, OTP program and status work.
// Functional notes
// - Error flags stay set; check after each program or after a sequence.
// - After an error, clear status before any further program.
// - Double word addresses differ only in the lowest address bit.
// - Quad word addresses differ only in the two lowest bits.
module fos_host
  import fos_pkg::*;
#(
  parameter logic [7:0] CMD_PROGRAM  = 8'h40,
  parameter logic [7:0] CMD_DWORD    = 8'h30,
  parameter logic [7:0] CMD_QWORD    = 8'h56,
  parameter logic [7:0] CMD_PROT     = 8'hC0,
  parameter logic [7:0] CMD_CLEAR    = 8'h50,
  parameter logic [7:0] CMD_QUERY    = 8'h98,
  parameter logic [7:0] CMD_STATUS   = 8'h70,
  parameter logic [7:0] CMD_ARRAY    = 8'hFF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        en_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [31:0] reg_rdata_o,
  output logic             irq_o,
  output fos_pins_t        fl_o,
  input  wire logic [15:0] fl_dq_i
);

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic is_prog(fos_op_t op);
    return ~op[2];
  endfunction

  function automatic logic [1:0] last_idx(fos_op_t op);
    return (op == OP_QWORD) ? 2'd3 : (op == OP_DWORD) ? 2'd1 : 2'd0;
  endfunction

  // Group address forced from the base, so the group can never straddle
  function automatic logic [20:0] word_addr(logic [20:0] b, logic [1:0] i, fos_op_t op);
    if (op == OP_QWORD) return {b[20:2], i};
    if (op == OP_DWORD) return {b[20:1], i[0]};
    return b;
  endfunction

  function automatic logic [7:0] cmd_of(fos_op_t op);
    unique case (op)
      OP_PROG:   return CMD_PROGRAM;
      OP_DWORD:  return CMD_DWORD;
      OP_QWORD:  return CMD_QWORD;
      OP_PROT:   return CMD_PROT;
      OP_CLEAR:  return CMD_CLEAR;
      OP_QUERY:  return CMD_QUERY;
      OP_STATUS: return CMD_STATUS;
      OP_ARRAY:  return CMD_ARRAY;
    endcase
  endfunction

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  fos_state_t          state_q, state_d;
  fos_op_t             op_q, op_d;
  logic [7:0]          cnt_q, cnt_d;
  logic [1:0]          idx_q, idx_d;
  logic                defer_q, defer_d;
  logic [20:0]         addr_q, addr_d;
  logic [3:0][15:0]    data_q, data_d;
  logic                err_pend_q, err_pend_d;
  logic [7:0]          fsr_q, fsr_d;
  logic [15:0]         rdata_q, rdata_d;
  logic [IRQ_W-1:0]    irq_stat_q, irq_stat_d;
  logic [IRQ_W-1:0]    irq_mask_q, irq_mask_d;
  logic [31:0]         bus_rd_q, bus_rd_d;
  fos_pins_t           pins_q, pins_d;
  logic [IRQ_W-1:0]    ev;
  logic                start_w;
  fos_op_t             op_w;
  logic [20:0]         wa;

  assign start_w = reg_we_i && reg_addr_i == REG_CTRL && reg_wdata_i[CTRL_START];
  assign op_w    = fos_op_t'(reg_wdata_i[CTRL_OP_LSB +: 3]);
  assign wa      = word_addr(addr_q, idx_q, op_q);

  // ---------------------------------------------------------------------
  // Sequencer and register file
  // ---------------------------------------------------------------------
  // Settings other than the IRQ mask are only taken while idle, so an op never sees its words change
  always_comb begin
    state_d    = state_q;
    op_d       = op_q;
    cnt_d      = cnt_q;
    idx_d      = idx_q;
    defer_d    = defer_q;
    addr_d     = addr_q;
    data_d     = data_q;
    err_pend_d = err_pend_q;
    fsr_d      = fsr_q;
    rdata_d    = rdata_q;
    irq_mask_d = irq_mask_q;
    ev         = '0;
    if (state_q != S_IDLE) begin
      cnt_d = cnt_q + 8'd1;
    end
    unique case (state_q)
      S_IDLE: begin
        cnt_d = 8'd0;
        if (reg_we_i && reg_addr_i == REG_ADDR) begin
          addr_d = reg_wdata_i[20:0];
        end
        for (int i = 0; i < 4; i++) begin
          if (reg_we_i && reg_addr_i == REG_DATA0 + 8'(4 * i)) begin
            data_d[i] = reg_wdata_i[15:0];
          end
        end
        if (start_w) begin
          if (is_prog(op_w) && err_pend_q) begin
            ev[IRQ_REFUSED] = 1'b1;
          end else begin
            op_d    = op_w;
            defer_d = reg_wdata_i[CTRL_DEFER];
            state_d = S_CMD;
          end
        end
      end
      S_CMD: begin
        if (cnt_q == WR_END) begin
          cnt_d   = 8'd0;
          idx_d   = 2'd0;
          state_d = is_prog(op_q) ? S_DATA : (op_q == OP_CLEAR) ? S_FIN : S_READ;
        end
      end
      S_DATA: begin
        if (cnt_q == WR_END) begin
          cnt_d = 8'd0;
          idx_d = idx_q + 2'd1;
          if (idx_q == last_idx(op_q)) begin
            state_d = S_POLL;
          end
        end
      end
      S_POLL: begin
        // Flash shows status after a program; re-read until it is ready
        if (cnt_q == RD_END) begin
          cnt_d = 8'd0;
          fsr_d = fl_dq_i[7:0];
          if (fl_dq_i[SR_READY]) begin
            state_d = S_FIN;
          end
        end
      end
      S_READ: begin
        if (cnt_q == RD_END) begin
          rdata_d = fl_dq_i;
          if (op_q == OP_STATUS) begin
            fsr_d = fl_dq_i[7:0];
          end
          state_d = S_FIN;
        end
      end
      S_FIN: begin
        state_d        = S_IDLE;
        ev[IRQ_DONE]   = 1'b1;
        if (op_q == OP_CLEAR) begin
          err_pend_d = 1'b0;
        end else if (((is_prog(op_q) && !defer_q) || op_q == OP_STATUS) &&
                     |(fsr_q & SR_ERR_MASK)) begin
          err_pend_d    = 1'b1;
          ev[IRQ_ERR]   = 1'b1;
        end
      end
      default: state_d = S_IDLE;
    endcase
    if (reg_we_i && reg_addr_i == REG_IRQ_MASK) begin
      irq_mask_d = reg_wdata_i[IRQ_W-1:0];
    end
    // New events win over a write-one clear in the same cycle
    irq_stat_d = irq_stat_q | ev;
    if (reg_we_i && reg_addr_i == REG_IRQ_STAT) begin
      irq_stat_d = (irq_stat_q & ~reg_wdata_i[IRQ_W-1:0]) | ev;
    end
    bus_rd_d = 32'h0000_0000;
    if (reg_re_i) begin
      unique case (reg_addr_i)
        REG_CTRL:     bus_rd_d = {27'd0, defer_q, op_q, 1'b0};
        REG_ADDR:     bus_rd_d = {11'd0, addr_q};
        REG_STAT:     bus_rd_d = {16'd0, fsr_q, 6'd0, err_pend_q, state_q != S_IDLE};
        REG_RDATA:    bus_rd_d = {16'd0, rdata_q};
        REG_IRQ_STAT: bus_rd_d = {29'd0, irq_stat_q};
        REG_IRQ_MASK: bus_rd_d = {29'd0, irq_mask_q};
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (reg_addr_i == REG_DATA0 + 8'(4 * i)) begin
              bus_rd_d = {16'd0, data_q[i]};
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Pin decode, registered one cycle behind the sequencer
  // ---------------------------------------------------------------------
  // The lag is folded into RD_END, so sampling still sees a full access time
  always_comb begin
    pins_d         = pins_q;
    pins_d.ce_n    = 1'b1;
    pins_d.oe_n    = 1'b1;
    pins_d.we_n    = 1'b1;
    pins_d.dq_oe_n = 1'b1;
    unique case (state_q)
      S_CMD, S_DATA: begin
        pins_d.ce_n    = 1'b0;
        pins_d.dq_oe_n = 1'b0;
        pins_d.we_n    = !(cnt_q >= 8'd1 && cnt_q <= WE_CYC);
        pins_d.addr    = (state_q == S_CMD) ? addr_q : wa;
        pins_d.dq      = (state_q == S_CMD) ? {8'h00, cmd_of(op_q)} : data_q[idx_q];
      end
      S_POLL, S_READ: begin
        pins_d.ce_n = 1'b0;
        pins_d.oe_n = (cnt_q == 8'd0);
        pins_d.addr = addr_q;
      end
      default: ;
    endcase
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q    <= S_IDLE;
      op_q       <= OP_PROG;
      cnt_q      <= 8'h00;
      idx_q      <= 2'd0;
      defer_q    <= 1'b0;
      addr_q     <= '0;
      data_q     <= '0;
      err_pend_q <= 1'b0;
      fsr_q      <= 8'h00;
      rdata_q    <= 16'h0000;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      bus_rd_q   <= 32'h0000_0000;
      pins_q     <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1,
                      addr: '0, dq: 16'h0000};
    end else if (en_i) begin
      state_q    <= state_d;
      op_q       <= op_d;
      cnt_q      <= cnt_d;
      idx_q      <= idx_d;
      defer_q    <= defer_d;
      addr_q     <= addr_d;
      data_q     <= data_d;
      err_pend_q <= err_pend_d;
      fsr_q      <= fsr_d;
      rdata_q    <= rdata_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      bus_rd_q   <= bus_rd_d;
      pins_q     <= pins_d;
    end
  end

  assign reg_rdata_o = bus_rd_q;
  assign irq_o       = |(irq_stat_q & irq_mask_q);
  assign fl_o        = pins_q;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  sequence s_refused_start;
    en_i && state_q == S_IDLE && start_w && is_prog(op_w) && err_pend_q;
  endsequence

  property p_refuse;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_refused_start |=> state_q == S_IDLE && irq_stat_q[IRQ_REFUSED];
  endproperty
  a_refuse: assert property (p_refuse) else $error("program started with error pending");

  property p_no_prog_cmd;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == S_CMD && is_prog(op_q)) |-> !err_pend_q;
  endproperty
  a_no_prog_cmd: assert property (p_no_prog_cmd) else $error("program command while error pending");

  property p_dword_addr;
    @(posedge clk_i) disable iff (!rst_n_i)
      (en_i && state_q == S_DATA && op_q == OP_DWORD) |=>
        pins_q.addr == {addr_q[20:1], $past(idx_q[0])};
  endproperty
  a_dword_addr: assert property (p_dword_addr) else $error("double word address out of pair");

  property p_qword_addr;
    @(posedge clk_i) disable iff (!rst_n_i)
      (en_i && state_q == S_DATA && op_q == OP_QWORD) |=>
        pins_q.addr == {addr_q[20:2], $past(idx_q)};
  endproperty
  a_qword_addr: assert property (p_qword_addr) else $error("quad word address out of group");

  sequence s_checked_fin;
    en_i && state_q == S_FIN && is_prog(op_q) && !defer_q && |(fsr_q & SR_ERR_MASK);
  endsequence

  property p_err_latch;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_checked_fin |=> err_pend_q && irq_stat_q[IRQ_ERR];
  endproperty
  a_err_latch: assert property (p_err_latch) else $error("error status not latched");

  property p_err_sticky;
    @(posedge clk_i) disable iff (!rst_n_i)
      (err_pend_q && !(state_q == S_FIN && op_q == OP_CLEAR)) |=> err_pend_q;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error pending lost without clear");

endmodule

// *** fos_pkg.sv ***
// Package for the flash OTP program sequencer host: timing, device map, own registers.
package fos_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_MHZ      = 100;
  localparam int T_WE_LOW_NS  = 50;   // Least write strobe width
  localparam int T_WE_HIGH_NS = 30;   // Least strobe high time after a write
  localparam int T_READ_NS    = 100;  // Least access time before sampling

  // Least times round up, never below one cycle
  function automatic int ns2cyc(int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [7:0] WE_CYC = 8'(ns2cyc(T_WE_LOW_NS));
  localparam logic [7:0] WR_END = 8'(ns2cyc(T_WE_LOW_NS) + ns2cyc(T_WE_HIGH_NS));
  localparam logic [7:0] RD_END = 8'(ns2cyc(T_READ_NS) + 1);

  // ---------------------------------------------------------------------
  // Device map (query offsets, security area, status bits)
  // ---------------------------------------------------------------------
  localparam logic [7:0]  QRY_PROT_FIELDS = 8'h43;
  localparam logic [7:0]  QRY_LOCK_LO     = 8'h44;
  localparam logic [7:0]  QRY_LOCK_HI     = 8'h45;
  localparam logic [7:0]  QRY_FACT_EXP    = 8'h46;
  localparam logic [7:0]  QRY_USER_EXP    = 8'h47;
  localparam logic [15:0] EXP_PROT_FIELDS = 16'h0001;
  localparam logic [15:0] EXP_LOCK_LO     = 16'h0080;
  localparam logic [15:0] EXP_LOCK_HI     = 16'h0000;
  localparam logic [15:0] EXP_BYTES_EXP   = 16'h0003;
  localparam logic [7:0]  SEC_LOCK_WORD   = 8'h80;
  localparam logic [7:0]  SEC_SERIAL      = 8'h81;
  localparam logic [7:0]  SEC_USER_OTP    = 8'h85;
  localparam logic [7:0]  SEC_USER_LAST   = 8'h8C;
  localparam int          SR_READY        = 7;
  localparam logic [7:0]  SR_ERR_MASK     = 8'h1A;  // Protected block, voltage, program error

  // ---------------------------------------------------------------------
  // Own registers
  // ---------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_ADDR     = 8'h04;
  localparam logic [7:0] REG_DATA0    = 8'h08;  // Four words, 08h to 14h
  localparam logic [7:0] REG_STAT     = 8'h18;
  localparam logic [7:0] REG_RDATA    = 8'h1C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK = 8'h24;
  localparam int CTRL_START  = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_DEFER  = 4;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_ERR     = 1;
  localparam int IRQ_REFUSED = 2;
  localparam int IRQ_W       = 3;

  typedef enum logic [2:0] {
    OP_PROG   = 3'b000,
    OP_DWORD  = 3'b001,
    OP_QWORD  = 3'b010,
    OP_PROT   = 3'b011,
    OP_CLEAR  = 3'b100,
    OP_QUERY  = 3'b101,
    OP_STATUS = 3'b110,
    OP_ARRAY  = 3'b111
  } fos_op_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CMD  = 3'b001,
    S_DATA = 3'b010,
    S_POLL = 3'b011,
    S_READ = 3'b100,
    S_FIN  = 3'b101
  } fos_state_t;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        dq_oe_n;
    logic [20:0] addr;
    logic [15:0] dq;
  } fos_pins_t;

endpackage

// *** fos_flash_model.sv ***
// Flash device model: query table, security area, sticky status flags.
module fos_flash_model
  import fos_pkg::*;
#(
  parameter logic [63:0] SERIAL_NUM = 64'h0123_4567_89AB_CDEF  // Arbitrary value
) (
  input  wire logic        clk_i,
  input  wire fos_pins_t   pins_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        vpp_bad_i,
  input  wire logic [15:0] busy_cyc_i,
  output logic      [15:0] dq_o = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [logic [20:0]];
  logic [20:0] grp [$];
  logic [15:0] dat [$];
  logic [20:0] wa;
  logic [15:0] wd;
  logic [15:0] busy = '0;
  logic [7:0]  cmd;
  logic [7:0]  lock = 8'hFF;
  logic [6:0]  flags = '0;
  logic [1:0]  mode = '0;
  logic        we_l = 1'b1;
  logic        ok;
  logic [3:0]  seen;
  int          left = 0;

  // Word returned in the current read mode
  function automatic logic [15:0] rd_word(input logic [20:0] a);
    if (mode == 2'd1) return {8'h00, busy == 0, flags};
    if (mode == 2'd2) begin
      case (a[7:0])
        8'h43:        return 16'h0001;
        8'h44:        return 16'h0080;
        8'h45:        return 16'h0000;
        8'h46, 8'h47: return 16'h0003;
        8'h80:        return {8'h00, lock};
        8'h81, 8'h82, 8'h83, 8'h84: return 16'(SERIAL_NUM >> (16 * (a[7:0] - 8'h81)));
        default: ;
      endcase
    end
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction

  // End of a program: group, supply and lock checks; flags only ever accumulate
  task commit();
    ok = 1'b1;
    seen = '0;
    foreach (grp[k]) begin
      ok &= (grp[k] >> (grp.size() / 2)) == (grp[0] >> (grp.size() / 2));
      seen[grp[k] % grp.size()] = 1'b1;
    end
    ok &= seen == 4'((1 << grp.size()) - 1);
    if (vpp_bad_i) flags |= 7'h18;
    else if (!ok) flags |= 7'h10;
    else if (cmd == 8'hC0 && grp[0][7:0] == 8'h80) lock &= dat[0][7:0];
    else if (cmd == 8'hC0 && !lock[1]) flags |= 7'h02;
    else foreach (grp[k]) mem[grp[k]] = (mem.exists(grp[k]) ? mem[grp[k]] : 16'hFFFF) & dat[k];
    busy = busy_cyc_i;
    mode = 2'd1;
    grp.delete();
    dat.delete();
  endtask

  // Reads answer a cycle late; a released bus toggles so it never looks valid
  always @(posedge clk_i) begin
    dq_o <= (!pins_i.ce_n && !pins_i.oe_n) ? rd_word(pins_i.addr) : ~dq_o;
    if (busy != 0) busy = busy - 1'b1;
    if (!we_l && pins_i.we_n && !pins_i.ce_n) begin
      if (left != 0) begin
        grp.push_back(wa);
        dat.push_back(wd);
        left--;
        if (left == 0) commit();
      end else begin
        cmd = wd[7:0];
        case (wd[7:0])
          8'h40, 8'h10, 8'hC0: left = 1;
          8'h30:               left = 2;
          8'h56:               left = 4;
          8'h50:               flags &= ~7'h1A;
          8'h70:               mode = 2'd1;
          8'h98:               mode = 2'd2;
          8'hFF:               mode = 2'd0;
          default: ;
        endcase
      end
    end
    we_l = pins_i.we_n;
    if (!pins_i.we_n) wa = pins_i.addr;
    if (!pins_i.we_n) wd = dq_i;
  end
endmodule

// *** tb_top.sv ***
// Testbench for the flash OTP program sequencer host against a flash model.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fos_pkg::*;

  localparam logic [63:0] SERIAL = 64'h0123_4567_89AB_CDEF;  // Arbitrary value
  localparam logic [7:0] Q_OFF [10] = '{8'h43, 8'h44, 8'h45, 8'h46, 8'h47,
                                        8'h80, 8'h81, 8'h82, 8'h83, 8'h84};
  localparam logic [15:0] Q_EXP [10] = '{16'h0001, 16'h0080, 16'h0000, 16'h0003, 16'h0003,
    16'h00FF, SERIAL[15:0], SERIAL[31:16], SERIAL[47:32], SERIAL[63:48]};

  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0;
  logic        reg_we_i = 1'b0;
  logic        reg_re_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        irq_o;
  fos_pins_t   fl_o;
  logic [15:0] dev_dq;
  logic [15:0] fl_dq;
  logic        en = 1'b1;
  logic        vpp_bad = 1'b0;
  logic [15:0] busy_cyc = 16'h0014;
  logic [2:0]  mask_q = '0;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #5 clk_i = ~clk_i;
  // Host wins the shared data wire while it drives
  assign fl_dq = fl_o.dq_oe_n ? dev_dq : fl_o.dq;

  fos_host i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .fl_o(fl_o), .fl_dq_i(fl_dq));
  fos_flash_model #(.SERIAL_NUM(SERIAL)) i_flash (.clk_i(clk_i), .pins_i(fl_o), .dq_i(fl_dq),
    .vpp_bad_i(vpp_bad), .busy_cyc_i(busy_cyc), .dq_o(dev_dq));

  // ---------------------------------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic load(input logic [15:0] w [4], input logic [2:0] m);
    for (int i = 0; i < 4; i++) wr(REG_DATA0 + 8'(4 * i), {16'h0000, w[i]});
    wr(REG_IRQ_MASK, {29'h0, m});
    mask_q = m;
  endtask

  // Start one operation, wait for done or refusal, judge and clear the events
  task automatic op(input fos_op_t o, input logic dfr, input logic [20:0] a,
                    input logic [2:0] e);
    logic [31:0] s;
    s = '0;
    wr(REG_ADDR, {11'h000, a});
    wr(REG_CTRL, {27'h0, dfr, o, 1'b1});
    while (!(s[IRQ_DONE] || s[IRQ_REFUSED])) rd(REG_IRQ_STAT, s);
    chk("irq_stat", {29'h0, e}, s);
    chk("irq_o", {31'h0, |(e & mask_q)}, {31'h0, irq_o});
    wr(REG_IRQ_STAT, 32'h0000_0007);
    #1 chk("irq_o cleared", 32'h0, {31'h0, irq_o});
  endtask

  task automatic peek(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk("register", e, d & m);
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_regs();
    peek(REG_CTRL, 32'hFFFF_FFFF, 32'h0);
    peek(REG_STAT, 32'hFFFF_FFFF, 32'h0);
    peek(REG_IRQ_MASK, 32'hFFFF_FFFF, 32'h0);
    peek(8'h30, 32'hFFFF_FFFF, 32'h0);
  endtask

  task automatic t_query();
    for (int i = 0; i < 10; i++) begin
      op(OP_QUERY, 1'b0, {13'h0, Q_OFF[i]}, 3'b001);
      peek(REG_RDATA, 32'hFFFF_FFFF, {16'h0, Q_EXP[i]});
    end
  endtask

  // Enable low mid-command: pins hold still, then the op still completes
  task automatic t_freeze();
    logic [31:0] s;
    logic [31:0] p;
    s = '0;
    wr(REG_ADDR, {11'h000, 21'h00_0044});
    wr(REG_CTRL, {27'h0, 1'b0, OP_QUERY, 1'b1});
    repeat (3) @(posedge clk_i);
    en <= 1'b0;
    @(posedge clk_i);
    #1 p = {fl_o.ce_n, fl_o.oe_n, fl_o.we_n, fl_o.dq_oe_n, 7'h00, fl_o.addr};
    repeat (20) @(posedge clk_i);
    #1 chk("frozen pins", p, {fl_o.ce_n, fl_o.oe_n, fl_o.we_n, fl_o.dq_oe_n, 7'h00, fl_o.addr});
    @(posedge clk_i);
    en <= 1'b1;
    while (!s[IRQ_DONE]) rd(REG_IRQ_STAT, s);
    chk("irq_stat", 32'h0000_0001, s);
    wr(REG_IRQ_STAT, 32'h0000_0007);
    peek(REG_RDATA, 32'hFFFF_FFFF, 32'h0000_0080);
  endtask

  // Unaligned start addresses: the host must still form the aligned group
  task automatic t_multi();
    logic [15:0] w [4];
    w = '{16'hA5A5, 16'h5A5A, 16'h0F0F, 16'hF0F0};
    load(w, 3'b111);
    op(OP_DWORD, 1'b0, 21'h00_0101, 3'b001);
    op(OP_QWORD, 1'b0, 21'h00_0203, 3'b001);
    for (int i = 0; i < 6; i++) begin
      op(OP_ARRAY, 1'b0, (i < 2) ? 21'(12'h100 + i) : 21'(12'h1FE + i), 3'b001);
      peek(REG_RDATA, 32'hFFFF_FFFF, {16'h0, w[(i < 2) ? i : i - 2]});
    end
  endtask

  task automatic t_error();
    wr(REG_IRQ_MASK, 32'h0000_0004);
    mask_q = 3'b100;
    vpp_bad = 1'b1;
    op(OP_PROG, 1'b0, 21'h00_0020, 3'b011);
    peek(REG_STAT, 32'h0000_1A03, 32'h0000_1802);
    vpp_bad = 1'b0;
    op(OP_PROG, 1'b0, 21'h00_0021, 3'b100);
    op(OP_CLEAR, 1'b0, 21'h00_0000, 3'b001);
    peek(REG_STAT, 32'h0000_0003, 32'h0);
    op(OP_PROG, 1'b0, 21'h00_0021, 3'b001);
  endtask

  // Slow device; flags survive a later good program until the status check
  task automatic t_defer();
    wr(REG_IRQ_MASK, 32'h0000_0003);
    mask_q = 3'b011;
    busy_cyc = 16'h012C;
    vpp_bad = 1'b1;
    op(OP_PROG, 1'b1, 21'h00_0030, 3'b001);
    vpp_bad = 1'b0;
    op(OP_PROG, 1'b1, 21'h00_0031, 3'b001);
    peek(REG_STAT, 32'h0000_0003, 32'h0);
    op(OP_STATUS, 1'b0, 21'h00_0000, 3'b011);
    op(OP_CLEAR, 1'b0, 21'h00_0000, 3'b001);
    busy_cyc = 16'h0014;
  endtask

  task automatic t_otp();
    logic [15:0] w [4];
    w = '{16'hFFFD, 16'hFFFF, 16'hFFFF, 16'hFFFF};
    load(w, 3'b111);
    op(OP_PROT, 1'b0, 21'h00_0080, 3'b001);
    op(OP_PROT, 1'b0, 21'h00_0086, 3'b011);
    op(OP_CLEAR, 1'b0, 21'h00_0000, 3'b001);
    op(OP_QUERY, 1'b0, 21'h00_0080, 3'b001);
    peek(REG_RDATA, 32'hFFFF_FFFF, 32'h0000_00FD);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hang guard well above the expected run length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_query();
    t_freeze();
    t_multi();
    t_error();
    t_defer();
    t_otp();
    wrap_up();
  end
endmodule
